// file: rtl/clk_ctrl_pkg.sv
// constants and types for the slow clock selector and clock manager
//
// What this block does
// - backup reset: rc on, crystal off, select zero
// - select one moves slow clock to crystal
// - five slow cycles resync before old oscillator off
// - bypass passes external pin clock, crystal disabled
// - select zero moves slow clock back to rc
// - four inputs: usb pll, system pll, slow, main
// - master divider of one, two, three, four
// - ddr clock at twice master clock
// - no ddr clock when master equals processor
// - per-peripheral clocks and two programmable outputs
// - usb full-speed divider is field plus one
// - master field 11 divides three, 01 two
// - usb full-speed input from system or usb pll, divided
// - idle, slow and standby operating modes
// - slow clock settings kept in backup domain
package clk_ctrl_pkg;

  // ****************************************
  // slow clock control reset values
  // ****************************************
  localparam logic       RC_EN_RESET   = 1'b1;
  localparam logic       XTAL_EN_RESET = 1'b0;
  localparam logic       SEL_RESET     = 1'b0;
  localparam logic       BYP_RESET     = 1'b0;
  localparam logic [2:0] RESYNC_EDGES  = 3'h5;

  // ****************************************
  // source and divider encodings
  // ****************************************
  localparam logic [1:0] SRC_SLOW   = 2'h0;
  localparam logic [1:0] SRC_MAIN   = 2'h1;
  localparam logic [1:0] SRC_SYS    = 2'h2;
  localparam logic [1:0] SRC_USB    = 2'h3;
  localparam logic [1:0] MASTER_DIVIDER_FIELD_ONE   = 2'h0;
  localparam logic [1:0] MASTER_DIVIDER_FIELD_TWO   = 2'h1;
  localparam logic [1:0] MASTER_DIVIDER_FIELD_FOUR  = 2'h2;
  localparam logic [1:0] MASTER_DIVIDER_FIELD_THREE = 2'h3;
  localparam int         PERIPH_N   = 32;

  typedef enum logic [1:0] {
    SW_IDLE, SW_PARK, SW_SYNC, SW_LAND
  } swap_e;

  typedef enum logic [1:0] {
    MODE_NORMAL, MODE_IDLE, MODE_SLOW, MODE_STANDBY
  } opmode_e;

endpackage : clk_ctrl_pkg

// file: rtl/slow_clock_select_and_pmc.sv
// slow clock source selector and system clock generator
module slow_clock_select_and_pmc
  import clk_ctrl_pkg::*;
(
  input  wire logic                MCLK,
  input  wire logic                RST,
  input  wire logic                RC_OSC_CLOCK,
  input  wire logic                CRYSTAL_OSC_CLOCK,
  input  wire logic                CRYSTAL_INPUT_PIN,
  input  wire logic                USB_PLL_CLOCK,
  input  wire logic                SYSTEM_PLL_CLOCK,
  input  wire logic                MAIN_CLOCK,
  input  wire logic                SLOW_CTRL_WRITE,
  input  wire logic                RC_OSC_ENABLE_IN,
  input  wire logic                CRYSTAL_OSC_ENABLE_IN,
  input  wire logic                SLOW_SOURCE_SELECT_IN,
  input  wire logic                CRYSTAL_BYPASS_IN,
  input  wire logic [1:0]          SYSTEM_SOURCE,
  input  wire logic [1:0]          PROC_PRESCALE,
  input  wire logic [1:0]          MASTER_DIVIDER_FIELD,
  input  wire logic                USB_FS_SOURCE,
  input  wire logic [3:0]          USB_FS_DIVIDER_FIELD,
  input  wire logic                MODE_WRITE,
  input  wire logic [1:0]          MODE_IN,
  input  wire logic                INTERRUPT_PENDING,
  input  wire logic [PERIPH_N-1:0] PERIPH_CLOCK_ENABLE,
  input  wire logic [1:0]          PROG_CLOCK_ENABLE,
  input  wire logic [3:0]          PROG_CLOCK_SOURCE,
  input  wire logic [3:0]          PROG_CLOCK_PRESCALE,
  output logic                     RC_OSC_ENABLE,
  output logic                     CRYSTAL_OSC_ENABLE,
  output logic                     CRYSTAL_BYPASS,
  output logic                     SLOW_SOURCE_SELECT,
  output logic                     SLOW_SOURCE_ACTIVE,
  output logic                     SLOW_SWITCH_BUSY,
  output logic                     SLOW_CLOCK,
  output logic [1:0]               OPER_MODE,
  output logic                     PROCESSOR_CLOCK,
  output logic                     MASTER_CLOCK,
  output logic                     DDR_CLOCK,
  output logic                     DDR_CLOCK_VALID,
  output logic                     USB_HS_CLOCK,
  output logic                     USB_HOST_FS_CLOCK_48,
  output logic                     USB_HOST_FS_CLOCK_12,
  output logic [PERIPH_N-1:0]      PERIPH_CLOCK,
  output logic                     PROG_CLOCK_OUT_A,
  output logic                     PROG_CLOCK_OUT_B
);
  // ****************************************
  // shared decoding
  // ****************************************
  function automatic logic pick(input logic [1:0] s, input logic [3:0] c);
    pick = c[s];
  endfunction : pick
  function automatic logic prescaled(input logic src, input logic [1:0] p,
                                     input logic [2:0] c);
    prescaled = (p == 2'h0) ? src : c[p - 2'h1];
  endfunction : prescaled

  // ****************************************
  // backup-domain slow clock control
  // ****************************************
  logic rc_en_q, rc_en_d, xt_en_q, xt_en_d;
  logic sel_q, sel_d, byp_q, byp_d;
  always_comb begin
    rc_en_d = rc_en_q;
    xt_en_d = xt_en_q;
    sel_d   = sel_q;
    byp_d   = byp_q;
    if (SLOW_CTRL_WRITE) begin
      rc_en_d = RC_OSC_ENABLE_IN;
      xt_en_d = CRYSTAL_OSC_ENABLE_IN;
      sel_d   = SLOW_SOURCE_SELECT_IN;
      byp_d   = CRYSTAL_BYPASS_IN;
    end
  end
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rc_en_q <= RC_EN_RESET;
      xt_en_q <= XTAL_EN_RESET;
      sel_q   <= SEL_RESET;
      byp_q   <= BYP_RESET;
    end else begin
      rc_en_q <= rc_en_d;
      xt_en_q <= xt_en_d;
      sel_q   <= sel_d;
      byp_q   <= byp_d;
    end
  end

  // ****************************************
  // glitch-free slow source switch
  // ****************************************
  logic       rc_src, xt_src, old_src, new_src;
  logic       rc_prev_q, xt_prev_q, new_prev;
  logic       act_q, act_d, slow_q, slow_d;
  logic [2:0] cnt_q, cnt_d;
  swap_e      sw_q, sw_d;
  assign rc_src   = RC_OSC_CLOCK & rc_en_q;
  // bypass takes the pin clock even with the oscillator off
  assign xt_src   = byp_q ? CRYSTAL_INPUT_PIN
                          : (CRYSTAL_OSC_CLOCK & xt_en_q);
  assign old_src  = act_q ? xt_src : rc_src;
  assign new_src  = act_q ? rc_src : xt_src;
  assign new_prev = act_q ? rc_prev_q : xt_prev_q;
  always_comb begin
    sw_d   = sw_q;
    act_d  = act_q;
    cnt_d  = cnt_q;
    slow_d = 1'b0;
    case (sw_q)
      SW_IDLE: begin
        slow_d = old_src;
        if (sel_q != act_q) begin
          sw_d = SW_PARK;
        end
      end
      SW_PARK: begin
        // hold until old source is low, never cut a high phase
        slow_d = old_src;
        if (!old_src) begin
          slow_d = 1'b0;
          cnt_d  = 3'h0;
          sw_d   = SW_SYNC;
        end
      end
      SW_SYNC: begin
        if (new_src && !new_prev) begin
          cnt_d = cnt_q + 3'h1;
        end
        if (cnt_q == RESYNC_EDGES) begin
          sw_d = SW_LAND;
        end
      end
      SW_LAND: begin
        if (!new_src) begin
          act_d = ~act_q;
          sw_d  = SW_IDLE;
        end
      end
      default: sw_d = SW_IDLE;
    endcase
  end
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sw_q      <= SW_IDLE;
      act_q     <= SEL_RESET;
      cnt_q     <= 3'h0;
      slow_q    <= 1'b0;
      rc_prev_q <= 1'b0;
      xt_prev_q <= 1'b0;
    end else begin
      sw_q      <= sw_d;
      act_q     <= act_d;
      cnt_q     <= cnt_d;
      slow_q    <= slow_d;
      rc_prev_q <= rc_src;
      xt_prev_q <= xt_src;
    end
  end

  // ****************************************
  // operating mode
  // ****************************************
  opmode_e mode_q, mode_d;
  logic    stopped, slow_forced;
  always_comb begin
    mode_d = mode_q;
    if (MODE_WRITE) begin
      mode_d = opmode_e'(MODE_IN);
    end else if (INTERRUPT_PENDING) begin
      case (mode_q)
        MODE_IDLE:    mode_d = MODE_NORMAL;
        MODE_STANDBY: mode_d = MODE_SLOW;
        default:      mode_d = mode_q;
      endcase
    end
  end
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      mode_q <= MODE_NORMAL;
    end else begin
      mode_q <= mode_d;
    end
  end
  assign stopped     = (mode_q == MODE_IDLE) || (mode_q == MODE_STANDBY);
  assign slow_forced = (mode_q == MODE_SLOW) || (mode_q == MODE_STANDBY);

  // ****************************************
  // processor, master and ddr clocks
  // ****************************************
  logic       sys_src, sys_prev_q, pck_raw, pck_prev_q;
  logic [1:0] css;
  logic [2:0] pre_q, pre_d, hc_q, hc_d, ratio, hmod;
  logic       pck_d, mck_d, ddr_d, ddr_ok, pck_q, mck_q, ddr_q;
  logic [3:0] srcs;
  assign srcs    = {USB_PLL_CLOCK, SYSTEM_PLL_CLOCK, MAIN_CLOCK, slow_q};
  assign css     = slow_forced ? SRC_SLOW : SYSTEM_SOURCE;
  assign sys_src = pick(css, srcs);
  assign pck_raw = prescaled(sys_src, PROC_PRESCALE, pre_q);
  always_comb begin
    case (MASTER_DIVIDER_FIELD)
      MASTER_DIVIDER_FIELD_ONE:   ratio = 3'h1;
      MASTER_DIVIDER_FIELD_TWO:   ratio = 3'h2;
      MASTER_DIVIDER_FIELD_THREE: ratio = 3'h3;
      default:    ratio = 3'h4;
    endcase
  end
  // hc counts processor half periods over one master period
  always_comb begin
    pre_d = pre_q;
    hc_d  = hc_q;
    if (sys_src && !sys_prev_q) begin
      pre_d = pre_q + 3'h1;
    end
    if (pck_raw != pck_prev_q) begin
      hc_d = ({1'b0, hc_q} + 4'h1 >= {ratio, 1'b0}) ? 3'h0 : hc_q + 3'h1;
    end
    hmod   = (hc_d >= ratio) ? hc_d - ratio : hc_d;
    mck_d  = (ratio == 3'h1) ? pck_raw : (hc_d < ratio);
    ddr_ok = (ratio != 3'h1);
    ddr_d  = ddr_ok && (hmod < ((ratio + 3'h1) >> 1));
    pck_d  = pck_raw && !stopped;
  end
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sys_prev_q <= 1'b0;
      pck_prev_q <= 1'b0;
      pre_q      <= 3'h0;
      hc_q       <= 3'h0;
      pck_q      <= 1'b0;
      mck_q      <= 1'b0;
      ddr_q      <= 1'b0;
    end else begin
      sys_prev_q <= sys_src;
      pck_prev_q <= pck_raw;
      pre_q      <= pre_d;
      hc_q       <= hc_d;
      pck_q      <= pck_d;
      mck_q      <= mck_d;
      ddr_q      <= ddr_d;
    end
  end

  // ****************************************
  // usb clocks
  // ****************************************
  logic       fs_src, fs_prev_q, fs48_q, fs48_d, fs12_q, fs12_d, hs_q;
  logic [3:0] fc_q, fc_d;
  logic [1:0] qc_q, qc_d;
  logic [4:0] fdiv;
  assign fs_src = USB_FS_SOURCE ? SYSTEM_PLL_CLOCK : USB_PLL_CLOCK;
  assign fdiv   = {1'b0, USB_FS_DIVIDER_FIELD} + 5'h1;
  always_comb begin
    fc_d = fc_q;
    qc_d = qc_q;
    if (fs_src && !fs_prev_q) begin
      fc_d = ({1'b0, fc_q} + 5'h1 >= fdiv) ? 4'h0 : fc_q + 4'h1;
    end
    fs48_d = (fdiv == 5'h1) ? fs_src
           : ({1'b0, fc_d} < ((fdiv + 5'h1) >> 1));
    if (fs48_d && !fs48_q) begin
      qc_d = qc_q + 2'h1;
    end
    fs12_d = qc_d[1];
  end
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      fs_prev_q <= 1'b0;
      fc_q      <= 4'h0;
      qc_q      <= 2'h0;
      fs48_q    <= 1'b0;
      fs12_q    <= 1'b0;
      hs_q      <= 1'b0;
    end else begin
      fs_prev_q <= fs_src;
      fc_q      <= fc_d;
      qc_q      <= qc_d;
      fs48_q    <= fs48_d;
      fs12_q    <= fs12_d;
      hs_q      <= USB_PLL_CLOCK;
    end
  end

  // ****************************************
  // peripheral and programmable clocks
  // ****************************************
  logic [PERIPH_N-1:0] per_q;
  logic [1:0]          prog_q;
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      per_q <= '0;
    end else begin
      per_q <= {PERIPH_N{mck_d}} & PERIPH_CLOCK_ENABLE;
    end
  end
  for (genvar i = 0; i < 2; i++) begin : g_prog
    logic       src, prev_q, out_d;
    logic [2:0] c_q, c_d;
    assign src = pick(PROG_CLOCK_SOURCE[2*i +: 2], srcs);
    always_comb begin
      c_d = (src && !prev_q) ? c_q + 3'h1 : c_q;
      out_d = PROG_CLOCK_ENABLE[i]
            && prescaled(src, PROG_CLOCK_PRESCALE[2*i +: 2], c_q);
    end
    always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
        prev_q    <= 1'b0;
        c_q       <= 3'h0;
        prog_q[i] <= 1'b0;
      end else begin
        prev_q    <= src;
        c_q       <= c_d;
        prog_q[i] <= out_d;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign RC_OSC_ENABLE        = rc_en_q;
  assign CRYSTAL_OSC_ENABLE   = xt_en_q;
  assign CRYSTAL_BYPASS       = byp_q;
  assign SLOW_SOURCE_SELECT   = sel_q;
  assign SLOW_SOURCE_ACTIVE   = act_q;
  assign SLOW_SWITCH_BUSY     = (sw_q != SW_IDLE);
  assign SLOW_CLOCK           = slow_q;
  assign OPER_MODE            = mode_q;
  assign PROCESSOR_CLOCK      = pck_q;
  assign MASTER_CLOCK         = mck_q;
  assign DDR_CLOCK            = ddr_q;
  assign DDR_CLOCK_VALID      = (ratio != 3'h1);
  assign USB_HS_CLOCK         = hs_q;
  assign USB_HOST_FS_CLOCK_48 = fs48_q;
  assign USB_HOST_FS_CLOCK_12 = fs12_q;
  assign PERIPH_CLOCK         = per_q;
  assign PROG_CLOCK_OUT_A     = prog_q[0];
  assign PROG_CLOCK_OUT_B     = prog_q[1];
endmodule : slow_clock_select_and_pmc

// file: bench/osc_model.sv
// oscillator and pll sources feeding the clock manager
module osc_model (
  input  wire logic MCLK,
  input  wire logic rc_on,
  input  wire logic xt_on,
  output logic      rc,
  output logic      xt,
  output logic      pin,
  output logic      usb_pll,
  output logic      spll,
  output logic      mainc
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  always @(posedge MCLK) cnt <= cnt + 1;
  // ****************************************
  // sources, periods in system clock cycles
  // ****************************************
  // oscillators stand still while disabled
  assign rc    = rc_on && (cnt % 6 < 3);
  assign xt    = xt_on && (cnt % 10 < 5);
  assign pin   = cnt % 14 < 7;
  assign usb_pll  = cnt % 6 < 3;
  assign spll  = cnt % 4 < 2;
  assign mainc = cnt % 8 < 4;
endmodule : osc_model

// file: bench/clk_ctrl_chk.sv
// port assertions for the slow clock selector and clock manager
module clk_ctrl_chk
  import clk_ctrl_pkg::*;
(
  input wire logic                MCLK,
  input wire logic                RST,
  input wire logic                SLOW_CTRL_WRITE,
  input wire logic                RC_OSC_ENABLE_IN,
  input wire logic                CRYSTAL_OSC_ENABLE_IN,
  input wire logic                SLOW_SOURCE_SELECT_IN,
  input wire logic                CRYSTAL_BYPASS_IN,
  input wire logic                MODE_WRITE,
  input wire logic [1:0]          MODE_IN,
  input wire logic                INTERRUPT_PENDING,
  input wire logic [PERIPH_N-1:0] PERIPH_CLOCK_ENABLE,
  input wire logic                RC_OSC_ENABLE,
  input wire logic                CRYSTAL_OSC_ENABLE,
  input wire logic                CRYSTAL_BYPASS,
  input wire logic                SLOW_SOURCE_SELECT,
  input wire logic                SLOW_SOURCE_ACTIVE,
  input wire logic                SLOW_SWITCH_BUSY,
  input wire logic                SLOW_CLOCK,
  input wire logic [1:0]          OPER_MODE,
  input wire logic                PROCESSOR_CLOCK,
  input wire logic [PERIPH_N-1:0] PERIPH_CLOCK
);
  logic [3:0] ctl_now;
  logic [3:0] ctl_new;
  assign ctl_now = {RC_OSC_ENABLE, CRYSTAL_OSC_ENABLE,
                    SLOW_SOURCE_SELECT, CRYSTAL_BYPASS};
  assign ctl_new = {RC_OSC_ENABLE_IN, CRYSTAL_OSC_ENABLE_IN,
                    SLOW_SOURCE_SELECT_IN, CRYSTAL_BYPASS_IN};
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // ****************************************
  // slow clock control and switching
  // ****************************************
  sequence busy_hold_s;
    SLOW_SWITCH_BUSY [*8];
  endsequence
  sequence land_s;
    !SLOW_SWITCH_BUSY;
  endsequence
  reset_val_a: assert property ($fell(RST) |-> ctl_now == 4'h8)
    else $error("slow control not at reset values");
  write_load_a: assert property (
    SLOW_CTRL_WRITE |=> ctl_now == $past(ctl_new))
    else $error("slow control write not loaded");
  ctrl_hold_a: assert property (!SLOW_CTRL_WRITE |=> $stable(ctl_now))
    else $error("slow control changed without write");
  switch_start_a: assert property (
    $changed(SLOW_SOURCE_SELECT) && !SLOW_SWITCH_BUSY |=> SLOW_SWITCH_BUSY)
    else $error("switch did not start");
  resync_hold_a: assert property (
    $rose(SLOW_SWITCH_BUSY) |-> busy_hold_s ##[1:600] land_s)
    else $error("resync too short or never ends");
  switch_land_a: assert property (
    $fell(SLOW_SWITCH_BUSY) |->
      SLOW_SOURCE_ACTIVE == SLOW_SOURCE_SELECT && !SLOW_CLOCK)
    else $error("switch landed badly");
  // ****************************************
  // operating modes and gating
  // ****************************************
  mode_load_a: assert property (
    MODE_WRITE |=> OPER_MODE == $past(MODE_IN))
    else $error("mode write not loaded");
  idle_wake_a: assert property (
    !MODE_WRITE && INTERRUPT_PENDING && OPER_MODE == MODE_IDLE
      |=> OPER_MODE == MODE_NORMAL)
    else $error("idle not woken");
  cpu_halt_a: assert property (
    (OPER_MODE inside {MODE_IDLE, MODE_STANDBY}) [*3] |-> !PROCESSOR_CLOCK)
    else $error("processor clock runs while halted");
  periph_gate_a: assert property (
    (PERIPH_CLOCK_ENABLE == '0) [*3] |-> PERIPH_CLOCK == '0)
    else $error("gated peripheral clock runs");
endmodule : clk_ctrl_chk

bind slow_clock_select_and_pmc clk_ctrl_chk i_clk_ctrl_chk (
  .MCLK(MCLK), .RST(RST), .SLOW_CTRL_WRITE(SLOW_CTRL_WRITE),
  .RC_OSC_ENABLE_IN(RC_OSC_ENABLE_IN),
  .CRYSTAL_OSC_ENABLE_IN(CRYSTAL_OSC_ENABLE_IN),
  .SLOW_SOURCE_SELECT_IN(SLOW_SOURCE_SELECT_IN),
  .CRYSTAL_BYPASS_IN(CRYSTAL_BYPASS_IN), .MODE_WRITE(MODE_WRITE),
  .MODE_IN(MODE_IN), .INTERRUPT_PENDING(INTERRUPT_PENDING),
  .PERIPH_CLOCK_ENABLE(PERIPH_CLOCK_ENABLE), .RC_OSC_ENABLE(RC_OSC_ENABLE),
  .CRYSTAL_OSC_ENABLE(CRYSTAL_OSC_ENABLE), .CRYSTAL_BYPASS(CRYSTAL_BYPASS),
  .SLOW_SOURCE_SELECT(SLOW_SOURCE_SELECT),
  .SLOW_SOURCE_ACTIVE(SLOW_SOURCE_ACTIVE),
  .SLOW_SWITCH_BUSY(SLOW_SWITCH_BUSY), .SLOW_CLOCK(SLOW_CLOCK),
  .OPER_MODE(OPER_MODE), .PROCESSOR_CLOCK(PROCESSOR_CLOCK),
  .PERIPH_CLOCK(PERIPH_CLOCK)
);

// file: bench/slow_clock_select_and_pmc_tb.sv
// self-checking bench for the slow clock selector and clock manager
module slow_clock_select_and_pmc_tb
  import clk_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst, wr, rc_i, xt_i, sel_i, byp_i, fsrc, mwr, irq;
  logic        rc_o, xt_o, pin, usb_pll, spll, mainc;
  logic [1:0]  src, pre, master_divider_field, mode_i, pcen, mode;
  logic [3:0]  fdiv, pcsrc, pcpre;
  logic [31:0] pen, per;
  logic        rc_en, xt_en, byp, sel, act, busy, slow_clock, processor_clock, master_clock, ddr;
  logic        ddr_ok, uhs, fs48, fs12, pa, pb;
  logic [8:0]  probes;
  logic [10:0] corner [5] = '{11'h469, 11'h6a9, 11'h477, 11'h400, 11'h35f};
  int          error_cnt = 0;
  int          tests_run = 0;
  int          slow_p = 6;
  int          seed;
  slow_clock_select_and_pmc i_slow_clock_select_and_pmc (
    .MCLK(mclk), .RST(rst), .RC_OSC_CLOCK(rc_o), .CRYSTAL_OSC_CLOCK(xt_o),
    .CRYSTAL_INPUT_PIN(pin), .USB_PLL_CLOCK(usb_pll), .SYSTEM_PLL_CLOCK(spll),
    .MAIN_CLOCK(mainc), .SLOW_CTRL_WRITE(wr), .RC_OSC_ENABLE_IN(rc_i),
    .CRYSTAL_OSC_ENABLE_IN(xt_i), .SLOW_SOURCE_SELECT_IN(sel_i),
    .CRYSTAL_BYPASS_IN(byp_i), .SYSTEM_SOURCE(src), .PROC_PRESCALE(pre),
    .MASTER_DIVIDER_FIELD(master_divider_field), .USB_FS_SOURCE(fsrc),
    .USB_FS_DIVIDER_FIELD(fdiv), .MODE_WRITE(mwr), .MODE_IN(mode_i),
    .INTERRUPT_PENDING(irq), .PERIPH_CLOCK_ENABLE(pen),
    .PROG_CLOCK_ENABLE(pcen), .PROG_CLOCK_SOURCE(pcsrc),
    .PROG_CLOCK_PRESCALE(pcpre), .RC_OSC_ENABLE(rc_en),
    .CRYSTAL_OSC_ENABLE(xt_en), .CRYSTAL_BYPASS(byp),
    .SLOW_SOURCE_SELECT(sel), .SLOW_SOURCE_ACTIVE(act),
    .SLOW_SWITCH_BUSY(busy), .SLOW_CLOCK(slow_clock), .OPER_MODE(mode),
    .PROCESSOR_CLOCK(processor_clock), .MASTER_CLOCK(master_clock), .DDR_CLOCK(ddr),
    .DDR_CLOCK_VALID(ddr_ok), .USB_HS_CLOCK(uhs),
    .USB_HOST_FS_CLOCK_48(fs48), .USB_HOST_FS_CLOCK_12(fs12),
    .PERIPH_CLOCK(per), .PROG_CLOCK_OUT_A(pa), .PROG_CLOCK_OUT_B(pb));
  osc_model i_osc_model (.MCLK(mclk), .rc_on(rc_en), .xt_on(xt_en),
    .rc(rc_o), .xt(xt_o), .pin(pin), .usb_pll(usb_pll), .spll(spll),
    .mainc(mainc));
  assign probes = {slow_clock, uhs, pb, pa, fs12, fs48, ddr, master_clock, processor_clock};
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // ****************************************
  // expectations and checks
  // ****************************************
  function automatic int sp(input logic [1:0] s);
    case (s)
      SRC_SLOW: return slow_p;
      SRC_MAIN: return 8;
      SRC_SYS:  return 4;
      default:  return 6;
    endcase
  endfunction : sp
  function automatic int md(input logic [1:0] f);
    return (f == MASTER_DIVIDER_FIELD_THREE) ? 3 : (1 << f);
  endfunction : md
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // period between the third and fourth rising edge of a probe
  task automatic meas(input int k, input int exp);
    int   n;
    int   r;
    logic last;
    n = 0;
    r = 0;
    last = probes[k];
    for (int i = 0; i < 4000 && r < 4; i++) begin
      @(posedge mclk);
      #1;
      n++;
      if (probes[k] === 1'b1 && last === 1'b0) r++;
      if (probes[k] === 1'b1 && last === 1'b0 && r < 4) n = 0;
      last = probes[k];
    end
    if (r < 4) error_cnt++;
    if (r < 4) finish_test();
    chk(n, exp);
  endtask : meas
  task automatic ctl(input logic [3:0] v);
    @(posedge mclk);
    {rc_i, xt_i, sel_i, byp_i} <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
    #1;
    chk({rc_en, xt_en, sel, byp}, v);
  endtask : ctl
  task automatic wait_sw(input logic a, input int p);
    int i;
    for (i = 0; i < 800 && busy !== 1'b0; i++) begin
      @(posedge mclk);
      #1;
    end
    if (i == 800) error_cnt++;
    if (i == 800) finish_test();
    chk(act, a);
    slow_p = p;
    meas(8, p);
  endtask : wait_sw
  task automatic run_cfg(input logic [10:0] c, input logic [7:0] pc);
    int pp;
    int fp;
    @(posedge mclk);
    {src, pre, master_divider_field, fsrc, fdiv} <= c;
    {pcsrc, pcpre} <= pc;
    @(posedge mclk);
    #1;
    pp = sp(src) << pre;
    fp = (fsrc ? 4 : 6) * (fdiv + 1);
    meas(0, pp);
    meas(1, pp * md(master_divider_field));
    if (master_divider_field == MASTER_DIVIDER_FIELD_TWO || master_divider_field == MASTER_DIVIDER_FIELD_FOUR) begin
      meas(2, pp * md(master_divider_field) / 2);
    end
    chk(ddr_ok, master_divider_field != MASTER_DIVIDER_FIELD_ONE);
    meas(3, fp);
    meas(4, fp * 4);
    meas(5, sp(pcsrc[1:0]) << pcpre[1:0]);
    meas(6, sp(pcsrc[3:2]) << pcpre[3:2]);
  endtask : run_cfg
  task automatic setm(input logic [1:0] m);
    @(posedge mclk);
    mode_i <= m;
    mwr <= 1'b1;
    @(posedge mclk);
    mwr <= 1'b0;
    @(posedge mclk);
    #1;
    chk(mode, m);
  endtask : setm
  task automatic wake(input logic [1:0] m);
    @(posedge mclk);
    irq <= 1'b1;
    @(posedge mclk);
    irq <= 1'b0;
    @(posedge mclk);
    #1;
    chk(mode, m);
  endtask : wake
  task automatic gate(input logic [31:0] en);
    logic [31:0] acc;
    @(posedge mclk);
    pen <= en;
    repeat (4) @(posedge mclk);
    acc = '0;
    repeat (600) begin
      @(posedge mclk);
      #1;
      acc |= per;
    end
    chk(acc, en);
  endtask : gate
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic acc;
    {rst, wr, rc_i, xt_i, sel_i, byp_i, fsrc, mwr, irq} = 9'h100;
    {master_divider_field, mode_i, pre, fdiv, pcsrc, pcpre} = '0;
    src = SRC_SYS;
    pcen = 2'h3;
    pen = '1;
    seed = $urandom(17242);
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk({rc_en, xt_en, sel, byp, act, busy, mode}, 8'h80);
    meas(7, 6);
    ctl(4'hc);
    repeat (40) @(posedge mclk);
    ctl(4'he);
    chk(busy, 1'b1);
    wait_sw(1'b1, 10);
    ctl(4'h6);
    ctl(4'h3);
    meas(8, 14);
    slow_p = 14;
    ctl(4'hb);
    repeat (40) @(posedge mclk);
    ctl(4'h9);
    wait_sw(1'b0, 6);
    ctl(4'h8);
    foreach (corner[j]) run_cfg(corner[j], 8'h1b);
    for (int j = 0; j < 6; j++) run_cfg(11'($urandom), 8'($urandom));
    setm(MODE_IDLE);
    repeat (3) @(posedge mclk);
    acc = 1'b0;
    repeat (20) begin
      @(posedge mclk);
      #1;
      acc |= processor_clock;
    end
    chk(acc, 1'b0);
    wake(MODE_NORMAL);
    setm(MODE_STANDBY);
    wake(MODE_SLOW);
    meas(0, slow_p << pre);
    setm(MODE_NORMAL);
    gate(32'h0);
    gate(32'($urandom));
    ctl(4'he);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk({rc_en, xt_en, sel, byp, act, busy, mode}, 8'h80);
    finish_test();
  end
endmodule : slow_clock_select_and_pmc_tb
